// file: shared/rxfc_pkg.sv
// Shared constants and types for the receive control block.
// Assumes a single 10 MHz reference clock and 16-bit serial commands.
package rxfc_pkg;
  // Power-on values of the configuration words
  localparam logic [15:0] RXFC_RATE_RESET = 16'hC813;
  localparam logic [15:0] RXFC_FIFO_RESET = 16'hCE87;
  localparam logic [15:0] RXFC_EXT_RESET = 16'hB0CA;
  // Command codes in the upper byte of a write command
  localparam logic [7:0] RXFC_RATE_CODE = 8'hC8;
  localparam logic [7:0] RXFC_FIFO_CODE = 8'hCE;
  localparam logic [7:0] RXFC_EXT_CODE = 8'hB0;
  // Field positions
  localparam int RXFC_PRESCALE_BIT = 7;
  localparam int RXFC_FE_BIT = 0;
  localparam int RXFC_FF_BIT = 1;
  localparam int RXFC_START_LSB = 2;
  localparam int RXFC_LEVEL_LSB = 4;
  localparam int RXFC_CTLS_BIT = 6;
  localparam int RXFC_DCAL_BIT = 4;
  localparam int RXFC_BW_LSB = 2;
  // Fill start codes
  localparam logic [1:0] RXFC_START_VDI = 2'h0;
  localparam logic [1:0] RXFC_START_SYNC = 2'h1;
  localparam logic [1:0] RXFC_START_ALWAYS = 2'h3;
  localparam logic [7:0] RXFC_SYNC_FIXED = 8'h2D;
  // Rate and counting constants
  localparam int RXFC_REF_CLK_HZ = 10000000;
  localparam logic [4:0] RXFC_BASE_LAST = 5'(29 - 1);
  localparam logic [2:0] RXFC_PRESCALE_LAST = 3'(8 - 1);
  localparam logic [2:0] RXFC_QUALITY_RUN = 3'h5;
  localparam logic [6:0] RXFC_FIFO_BITS = 7'h40;
  localparam logic [9:0] RXFC_TAIL_LONG = 10'h200;
  localparam logic [9:0] RXFC_TAIL_SHORT = 10'h080;
  localparam logic [4:0] RXFC_CMD_BITS = 5'h10;
  localparam logic [4:0] RXFC_STATUS_CLEAR_AT = 5'h3;
  localparam int RXFC_WORD_W = 8;
  localparam int RXFC_DEPTH = 8;

  typedef enum logic [1:0] {
    RXFC_SP_IDLE = 2'b00,
    RXFC_SP_CMD = 2'b01,
    RXFC_SP_STAT = 2'b10,
    RXFC_SP_FIFO = 2'b11
  } rxfc_sp_state_t;

  // Status word, first bit shifted out at the top
  typedef struct packed {
    logic fill_threshold_flag;
    logic buffer_overflow_flag;
    logic wake_timer_flag;
    logic low_supply_flag;
    logic buffer_empty_flag;
    logic signal_strength_flag;
    logic data_quality_flag;
    logic bit_sync_lock_flag;
    logic freq_cycle_toggle;
    logic freq_repeat_match;
    logic offset_sign;
    logic [4:0] offset_magnitude;
  } rxfc_status_t;

  // Frequency correction inputs from the analog side
  typedef struct packed {
    logic cycle_done;
    logic repeat_match;
    logic sign;
    logic [4:0] magnitude;
  } rxfc_freq_t;
endpackage : rxfc_pkg

// file: logic/rxfc_ctrl.sv
// Receive-side control: serial command port, bit rate divider, quality detector,
// sync search, 64-bit receive buffer and status readout.
// Assumes all inputs, including the serial pins, are synchronous to clock.
`timescale 1ns/1ns

// Word FIFO between bit assembly and the host read shifter
module rxfc_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock, // Reference clock
  input wire logic rst_n, // Synchronous reset
  input wire logic flush, // Drop all contents
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Read accept
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Flags come straight from the occupancy count
  assign in_ready = cnt_q != DEPTH[AW:0];
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  // Pointers wrap naturally; depth is a power of two
  always_ff @(posedge clock)
  begin
    if (!rst_n || flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage is not reset; reads are gated by the count
  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule : rxfc_word_fifo

module rxfc_ctrl (
  input wire logic clock, // 10 MHz reference
  input wire logic rst_n, // Synchronous reset
  input wire logic spi_sel_n, // Command select
  input wire logic spi_sck, // Serial clock
  input wire logic spi_sdi, // Serial data in
  output logic spi_sdo, // Serial data out
  output logic irq_out_n, // Interrupt line
  input wire logic rx_on, // Receiver enabled
  input wire logic analog_filter_sel, // Analog filter chosen
  input wire logic wake_on_irq_en, // Wake on interrupt
  input wire logic osc_run_en, // Oscillator enable
  output logic osc_run, // Oscillator running
  input wire logic [2:0] quality_threshold, // Quality threshold
  input wire logic [2:0] quality_value, // Quality per bit
  input wire logic rx_data_in, // Demodulated data
  input wire logic valid_data_indicator, // Valid data
  input wire logic [7:0] sync_pattern_low, // Second sync byte
  input wire logic buffer_select_n, // Buffer select via data pin
  output logic data_pin_o, // Received data
  output logic data_pin_oe, // Data pin driven
  output logic recovered_bit_clock, // Bit clock or threshold flag
  output logic data_quality_flag, // Quality good
  input wire logic wake_event, // Wake timer event
  input wire logic low_supply_in, // Supply below limit
  input wire logic signal_strength_in, // Strength above limit
  input wire logic bit_sync_lock_in, // Clock recovery locked
  input wire rxfc_pkg::rxfc_freq_t freq_in, // Frequency correction
  output logic clock_tail_long, // Long tail selected
  output logic [9:0] clock_tail_bits, // Tail length
  output logic wake_cal_disable, // Calibration off
  output logic [1:0] loop_bw_select // Loop bandwidth
);
  import rxfc_pkg::*;

  logic [15:0] rate_q, fifo_q, ext_q, cmd_q;
  logic [4:0] c29_q;
  logic [2:0] pre_q;
  logic [6:0] div_q;
  logic [2:0] run_q;
  logic seen_hi_q, seen_lo_q, bit_q, bit_tick_q;
  logic [15:0] sync_sh_q;
  logic fill_started_q;
  logic [7:0] asm_q, rd_q;
  logic [2:0] asm_n_q;
  logic [3:0] rd_n_q;
  logic [6:0] count_q;
  logic ovf_q, wake_q, lbd_irq_q, low_prev_q, toggle_q;
  logic sck_prev_q, irq_n_q, osc_q, sdo_q;
  logic [4:0] n_q;
  rxfc_sp_state_t sp_q;
  rxfc_status_t snap_q, status;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  // Configuration fields
  wire prescale_on = rate_q[RXFC_PRESCALE_BIT];
  wire [6:0] rate_divider = rate_q[6:0];
  wire buffer_mode_en = fifo_q[RXFC_FE_BIT];
  wire sync_fill_en = fifo_q[RXFC_FF_BIT];
  wire [1:0] fill_start_select = fifo_q[RXFC_START_LSB +: 2];
  wire [3:0] fill_level_low = fifo_q[RXFC_LEVEL_LSB +: 4];
  wire [1:0] fill_level_high = ext_q[1:0];
  wire [6:0] fill_level = {1'b0, fill_level_high, fill_level_low};

  // Side settings
  assign clock_tail_long = ext_q[RXFC_CTLS_BIT];
  assign clock_tail_bits = clock_tail_long ? RXFC_TAIL_LONG : RXFC_TAIL_SHORT;
  assign wake_cal_disable = ext_q[RXFC_DCAL_BIT];
  assign loop_bw_select = ext_q[RXFC_BW_LSB +: 2];

  // Rate chain: /29, optional /8, then /(R+1)
  wire recov_on = rx_on && !analog_filter_sel;
  wire t29 = c29_q == RXFC_BASE_LAST;
  wire tpre = t29 && (!prescale_on || pre_q == RXFC_PRESCALE_LAST);
  wire bit_tick = recov_on && tpre && div_q == rate_divider;

  always_ff @(posedge clock)
  begin
    if (!rst_n || !recov_on)
    begin
      c29_q <= '0;
      pre_q <= '0;
      div_q <= '0;
    end
    else
    begin
      c29_q <= t29 ? '0 : c29_q + 5'h01;
      if (t29)
        pre_q <= (tpre || !prescale_on) ? '0 : pre_q + 3'h1;
      if (tpre)
        div_q <= bit_tick ? '0 : div_q + 7'h01;
    end
  end

  // Quality run: five good bits in a row, at least one of each level
  wire bit_good = quality_value > quality_threshold;
  assign data_quality_flag = rx_on && run_q == RXFC_QUALITY_RUN && seen_hi_q && seen_lo_q;
  always_ff @(posedge clock)
  begin
    if (!rst_n || !rx_on)
    begin
      run_q <= '0;
      seen_hi_q <= 1'b0;
      seen_lo_q <= 1'b0;
    end
    else if (bit_tick && !bit_good)
    begin
      run_q <= '0;
      seen_hi_q <= 1'b0;
      seen_lo_q <= 1'b0;
    end
    else if (bit_tick)
    begin
      run_q <= (run_q == RXFC_QUALITY_RUN) ? run_q : run_q + 3'h1;
      seen_hi_q <= seen_hi_q | rx_data_in;
      seen_lo_q <= seen_lo_q | !rx_data_in;
    end
  end

  // Sync search and fill start
  wire sync_match = sync_sh_q == {RXFC_SYNC_FIXED, sync_pattern_low};
  wire start_cond = (fill_start_select == RXFC_START_VDI && valid_data_indicator) ||
                    (fill_start_select == RXFC_START_SYNC && sync_match) ||
                    (fill_start_select == RXFC_START_ALWAYS);
  wire buf_ok = buffer_mode_en && recov_on;
  wire wr_fifo_cmd;
  wire [15:0] cmd_word;
  // A write that clears ff or fe drops everything; re-setting ff starts a fresh search
  wire flush = !buffer_mode_en || (wr_fifo_cmd && (!cmd_word[RXFC_FF_BIT] || !cmd_word[RXFC_FE_BIT]));
  wire fill_active = buf_ok && sync_fill_en && fill_started_q;
  wire pop_host;
  wire full_word = asm_n_q == 3'h7;
  wire at_cap = count_q == RXFC_FIFO_BITS;
  // Back-pressure: a completing byte waits for FIFO space
  wire fill_accept = bit_tick && fill_active && !at_cap && !(full_word && !fifo_in_ready);
  wire overflow_hit = bit_tick && fill_active && at_cap;

  always_ff @(posedge clock)
  begin
    if (!rst_n || flush)
      fill_started_q <= 1'b0;
    else if (buf_ok && sync_fill_en && start_cond)
      fill_started_q <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sync_sh_q <= '0;
    else if (bit_tick)
      sync_sh_q <= {sync_sh_q[14:0], rx_data_in};
  end

  // Bit assembly into bytes
  always_ff @(posedge clock)
  begin
    if (!rst_n || flush)
    begin
      asm_q <= '0;
      asm_n_q <= '0;
    end
    else if (fill_accept)
    begin
      asm_q <= {asm_q[6:0], rx_data_in};
      asm_n_q <= asm_n_q + 3'h1;
    end
  end

  rxfc_word_fifo #(.WIDTH(RXFC_WORD_W), .DEPTH(RXFC_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(fill_accept && full_word),
    .in_ready(fifo_in_ready),
    .in_data({asm_q[6:0], rx_data_in}),
    .out_valid(fifo_out_valid),
    .out_ready(rd_n_q == 4'h0),
    .out_data(fifo_out_data)
  );

  // Host read shifter; only whole bytes become readable
  always_ff @(posedge clock)
  begin
    if (!rst_n || flush)
    begin
      rd_q <= '0;
      rd_n_q <= '0;
    end
    else if (rd_n_q == 4'h0 && fifo_out_valid)
    begin
      rd_q <= fifo_out_data;
      rd_n_q <= 4'h8;
    end
    else if (pop_host)
    begin
      rd_q <= {rd_q[6:0], 1'b0};
      rd_n_q <= rd_n_q - 4'h1;
    end
  end

  // Stored bit count drives the threshold and empty flags
  always_ff @(posedge clock)
  begin
    if (!rst_n || flush)
      count_q <= '0;
    else
      count_q <= count_q + 7'(fill_accept) - 7'(pop_host);
  end

  wire fill_threshold_flag = buf_ok && fill_level != 7'h00 && count_q >= fill_level;

  // Serial port edge detect; inputs already synchronous
  wire sck_rise = spi_sck && !sck_prev_q;
  wire stat_clear = sp_q == RXFC_SP_STAT && sck_rise && n_q == RXFC_STATUS_CLEAR_AT;
  assign pop_host = sp_q == RXFC_SP_FIFO && sck_rise && rd_n_q != 4'h0;
  assign cmd_word = cmd_q;
  wire apply = sp_q == RXFC_SP_CMD && spi_sel_n && n_q == RXFC_CMD_BITS;
  assign wr_fifo_cmd = apply && cmd_q[15:8] == RXFC_FIFO_CODE;

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ovf_q <= 1'b0;
      wake_q <= 1'b0;
      lbd_irq_q <= 1'b0;
      low_prev_q <= 1'b0;
      toggle_q <= 1'b0;
    end
    else
    begin
      ovf_q <= overflow_hit || (ovf_q && !stat_clear && !flush);
      wake_q <= wake_event || (wake_q && !stat_clear);
      lbd_irq_q <= (low_supply_in && !low_prev_q) || (lbd_irq_q && !stat_clear);
      low_prev_q <= low_supply_in;
      if (freq_in.cycle_done)
        toggle_q <= !toggle_q;
    end
  end

  // Status word in shift order
  assign status = '{fill_threshold_flag: fill_threshold_flag, buffer_overflow_flag: ovf_q,
                    wake_timer_flag: wake_q, low_supply_flag: low_supply_in || lbd_irq_q,
                    buffer_empty_flag: count_q == 7'h00, signal_strength_flag: signal_strength_in,
                    data_quality_flag: data_quality_flag, bit_sync_lock_flag: bit_sync_lock_in && recov_on,
                    freq_cycle_toggle: toggle_q, freq_repeat_match: freq_in.repeat_match,
                    offset_sign: freq_in.sign, offset_magnitude: freq_in.magnitude};

  // Serial sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sp_q <= RXFC_SP_IDLE;
      n_q <= '0;
      cmd_q <= '0;
      snap_q <= '0;
      sdo_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= spi_sck;
      case (sp_q)
        RXFC_SP_IDLE:
        begin
          n_q <= '0;
          sdo_q <= 1'b0;
          if (!spi_sel_n)
            sp_q <= RXFC_SP_CMD;
          else if (!buffer_select_n && buf_ok)
            sp_q <= RXFC_SP_FIFO;
        end
        RXFC_SP_CMD:
        begin
          if (spi_sel_n)
            sp_q <= RXFC_SP_IDLE;
          else if (sck_rise && n_q == 5'h00 && !spi_sdi)
          begin
            sp_q <= RXFC_SP_STAT;
            snap_q <= status;
            sdo_q <= status[15];
            n_q <= 5'h01;
          end
          else if (sck_rise && n_q != RXFC_CMD_BITS)
          begin
            cmd_q <= {cmd_q[14:0], spi_sdi};
            n_q <= n_q + 5'h01;
          end
        end
        RXFC_SP_STAT:
        begin
          if (spi_sel_n)
            sp_q <= RXFC_SP_IDLE;
          else if (sck_rise && n_q != RXFC_CMD_BITS)
          begin
            sdo_q <= snap_q[4'(15 - n_q)];
            n_q <= n_q + 5'h01;
          end
        end
        RXFC_SP_FIFO:
        begin
          // One cycle lag is safe: the host clock runs at most a quarter of ours
          sdo_q <= rd_q[7];
          if (buffer_select_n || !buf_ok)
            sp_q <= RXFC_SP_IDLE;
        end
        default: sp_q <= RXFC_SP_IDLE;
      endcase
    end
  end

  // Configuration words take effect when select rises after 16 bits
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rate_q <= RXFC_RATE_RESET;
      fifo_q <= RXFC_FIFO_RESET;
      ext_q <= RXFC_EXT_RESET;
    end
    else if (apply)
    begin
      if (cmd_q[15:8] == RXFC_RATE_CODE)
        rate_q <= cmd_q;
      if (cmd_q[15:8] == RXFC_FIFO_CODE)
        fifo_q <= cmd_q;
      if (cmd_q[15:8] == RXFC_EXT_CODE)
        ext_q <= cmd_q;
    end
  end

  // Interrupt, oscillator and pin outputs
  wire irq_active = fill_threshold_flag || ovf_q || wake_q || lbd_irq_q;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_n_q <= 1'b1;
      osc_q <= 1'b1;
      bit_q <= 1'b0;
      bit_tick_q <= 1'b0;
    end
    else
    begin
      irq_n_q <= !irq_active;
      osc_q <= osc_run_en || (wake_on_irq_en && irq_active);
      bit_tick_q <= bit_tick;
      if (bit_tick)
        bit_q <= rx_data_in;
    end
  end

  assign spi_sdo = sdo_q;
  assign irq_out_n = irq_n_q;
  assign osc_run = osc_q;
  assign data_pin_o = bit_q;
  assign data_pin_oe = !buffer_mode_en;
  assign recovered_bit_clock = buffer_mode_en ? fill_threshold_flag : bit_tick_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_analog_off;
    analog_filter_sel |-> !fill_accept && !bit_tick;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("buffer filled with analog filter");
  property p_osc_hold;
    wake_on_irq_en && irq_active |=> osc_run;
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator stopped with interrupt");
  // The flag may only rise on a good bit, never on a counter glitch
  property p_quality;
    $rose(data_quality_flag) |-> $past(bit_tick && bit_good) &&
      run_q == RXFC_QUALITY_RUN && seen_hi_q && seen_lo_q;
  endproperty
  a_quality: assert property (p_quality) else $error("quality flag early");
  property p_rate;
    bit_tick |-> c29_q == RXFC_BASE_LAST && div_q == rate_divider &&
      (!prescale_on || pre_q == RXFC_PRESCALE_LAST);
  endproperty
  a_rate: assert property (p_rate) else $error("bit tick off divider");
  property p_no_start;
    fill_start_select == 2'b10 && !fill_started_q |=> !fill_started_q;
  endproperty
  a_no_start: assert property (p_no_start) else $error("fill started on code two");
  property p_fill_stop;
    !sync_fill_en |-> !fill_accept;
  endproperty
  a_fill_stop: assert property (p_fill_stop) else $error("filled without enable");
  property p_mode_clear;
    !buffer_mode_en |=> count_q == 7'h00 && !fill_started_q;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("count kept without buffer mode");
  property p_read_start;
    sp_q == RXFC_SP_CMD && !spi_sel_n && sck_rise && n_q == 5'h00 && !spi_sdi |=> spi_sdo == $past(status[15]);
  endproperty
  a_read_start: assert property (p_read_start) else $error("status bit not shifted");
  property p_read_clear;
    stat_clear && !wake_event |=> !wake_q ##1 irq_out_n || fill_threshold_flag || ovf_q || lbd_irq_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("wake flag not cleared");
  property p_toggle;
    freq_in.cycle_done |=> toggle_q != $past(toggle_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not invert");
endmodule : rxfc_ctrl

// file: verif/rxfc_host_model.sv
// Host microcontroller model: drives serial commands and buffer reads.
// Assumes it is called from the bench and changes pins after the falling edge.
`timescale 1ns/1ns
module rxfc_host_model (
  input wire logic clock, // Reference clock
  input wire logic spi_sdo, // Serial data from the block
  output logic spi_sel_n, // Command select
  output logic spi_sck, // Serial clock
  output logic spi_sdi, // Serial data to the block
  output logic buffer_select_n // Buffer select, always driven
);
  // Idle pins; the select input is never left floating
  initial
  begin
    spi_sel_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b1;
    buffer_select_n = 1'b1;
  end

  // One bit: sck high and low two cycles each, sdo taken just before next rise
  task automatic bit_io(input logic b, output logic o);
    spi_sdi = b;
    spi_sck = 1'b1;
    repeat (2) @(negedge clock);
    spi_sck = 1'b0;
    repeat (2) @(negedge clock);
    o = spi_sdo;
  endtask : bit_io

  // Whole 16-bit word, first bit zero reads status; sdi flips when released
  task automatic cmd(input logic [15:0] w, output logic [15:0] r);
    spi_sel_n = 1'b0;
    @(negedge clock);
    for (int i = 15; i >= 0; i--)
      bit_io(w[i], r[i]);
    spi_sel_n = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (3) @(negedge clock);
  endtask : cmd

  // Buffer read: head bit shown first, each rise pops it
  task automatic buf_rd(output logic [7:0] d);
    logic junk;
    buffer_select_n = 1'b0;
    repeat (3) @(negedge clock);
    for (int i = 7; i >= 0; i--)
    begin
      d[i] = spi_sdo;
      bit_io(~spi_sdi, junk);
    end
    buffer_select_n = 1'b1;
    repeat (3) @(negedge clock);
  endtask : buf_rd
endmodule : rxfc_host_model

// file: verif/tb_top.sv
// Self-checking bench for the receive control block.
// Assumes the host model drives the serial pins; other inputs change at falling edges.
`timescale 1ns/1ns
module tb_top;
  import rxfc_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, spi_sel_n, spi_sck, spi_sdi, spi_sdo, irq_out_n;
  logic rx_on = 1'b0, analog_filter_sel = 1'b0, wake_on_irq_en = 1'b1, osc_run_en = 1'b0, osc_run;
  logic [2:0] quality_threshold = 3'h5, quality_value = 3'h0;
  logic rx_data_in = 1'b1, valid_data_indicator = 1'b0, buffer_select_n, data_pin_o, data_pin_oe;
  logic [7:0] sync_pattern_low = 8'hD4;
  logic recovered_bit_clock, data_quality_flag, wake_event = 1'b0, low_supply_in = 1'b0;
  logic signal_strength_in = 1'b1, bit_sync_lock_in = 1'b1, clock_tail_long, wake_cal_disable;
  rxfc_freq_t freq_in = '{1'b0, 1'b1, 1'b0, 5'h15};
  logic [9:0] clock_tail_bits;
  logic [1:0] loop_bw_select;
  logic [15:0] r;
  int err_total = 0, check_count = 0;

  always #50 clock = ~clock;

  rxfc_ctrl i_dut (.clock, .rst_n, .spi_sel_n, .spi_sck, .spi_sdi, .spi_sdo, .irq_out_n, .rx_on,
    .analog_filter_sel, .wake_on_irq_en, .osc_run_en, .osc_run, .quality_threshold, .quality_value,
    .rx_data_in, .valid_data_indicator, .sync_pattern_low, .buffer_select_n, .data_pin_o, .data_pin_oe,
    .recovered_bit_clock, .data_quality_flag, .wake_event, .low_supply_in, .signal_strength_in,
    .bit_sync_lock_in, .freq_in, .clock_tail_long, .clock_tail_bits, .wake_cal_disable, .loop_bw_select);

  rxfc_host_model i_host (.clock, .spi_sdo, .spi_sel_n, .spi_sck, .spi_sdi, .buffer_select_n);

  // Compare and count; four-state match so unknowns fail
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Cycles between two bit clock pulses, bounded
  task automatic gap(output int n);
    n = 0;
    while (recovered_bit_clock !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    n = 1;
    while (recovered_bit_clock !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
  endtask : gap

  task automatic t_reset;
    chk(16'(clock_tail_bits), 16'h0200, "tail");
    chk(16'(loop_bw_select), 16'h0002, "bw");
    chk(16'(wake_cal_disable), 16'h0000, "dcal");
    chk(16'(data_pin_oe), 16'h0000, "pin oe");
    $display("test reset done");
  endtask : t_reset

  // Wake event and a finished correction cycle, then two status reads
  task automatic t_status;
    wake_event = 1'b1;
    low_supply_in = 1'b1;
    freq_in.cycle_done = 1'b1;
    @(negedge clock);
    wake_event = 1'b0;
    low_supply_in = 1'b0;
    freq_in.cycle_done = 1'b0;
    repeat (3) @(negedge clock);
    chk(16'(irq_out_n), 16'h0000, "irq set");
    chk(16'(osc_run), 16'h0001, "osc wake");
    i_host.cmd(16'h0000, r);
    chk(r, 16'h3CD5, "status 1");
    repeat (3) @(negedge clock);
    chk(16'(irq_out_n), 16'h0001, "irq clr");
    chk(16'(osc_run), 16'h0000, "osc off");
    i_host.cmd(16'h0000, r);
    chk(r, 16'h0CD5, "status 2");
    $display("test status done");
  endtask : t_status

  // Every bandwidth code, with tail set from its low bit and calibration off from its high bit
  task automatic t_ext;
    for (int b = 0; b < 4; b++)
    begin
      i_host.cmd({8'hB0, 1'b1, b[0], 1'b0, b[1], b[1:0], 2'b00}, r);
      chk(16'(loop_bw_select), 16'(b), "bw");
      chk(16'(clock_tail_bits), b[0] ? 16'h0200 : 16'h0080, "tail");
      chk(16'(clock_tail_long), 16'(b[0]), "ctls");
      chk(16'(wake_cal_disable), 16'(b[1]), "dcal");
    end
    i_host.cmd(16'hA5F0, r);
    chk(16'(loop_bw_select), 16'h0003, "bad code");
    i_host.cmd(16'hB0C8, r);
    $display("test ext done");
  endtask : t_ext

  // Bit clock period for two divider settings, then analog filter stops it
  task automatic t_rate;
    int n;
    i_host.cmd(16'hCE86, r);
    chk(16'(data_pin_oe), 16'h0001, "pin oe");
    i_host.cmd(16'hC800, r);
    rx_on = 1'b1;
    gap(n);
    chk(16'(n), 16'h001D, "rate 29");
    chk(16'(data_pin_o), 16'h0001, "data");
    // Good quality, alternating bits at the exact rate: flag after the fifth bit only
    quality_value = 3'h6;
    rx_data_in = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      chk(16'(data_quality_flag), 16'h0000, "dqd early");
      gap(n);
      rx_data_in = ~rx_data_in;
    end
    chk(16'(data_quality_flag), 16'h0001, "dqd");
    i_host.cmd(16'hC881, r);
    gap(n);
    gap(n);
    chk(16'(n), 16'h01D0, "rate 464");
    analog_filter_sel = 1'b1;
    gap(n);
    chk(16'(n), 16'h07D0, "analog");
    analog_filter_sel = 1'b0;
    rx_on = 1'b0;
    $display("test rate done");
  endtask : t_rate

  // Fill to level 8, read a byte, then restart the search
  task automatic t_fifo;
    int k;
    logic [7:0] d;
    i_host.cmd(16'hC800, r);
    i_host.cmd(16'hCE8F, r);
    rx_on = 1'b1;
    k = 0;
    while (recovered_bit_clock !== 1'b1 && k < 600)
    begin
      @(negedge clock);
      k++;
    end
    chk(16'(k >= 203 && k <= 300), 16'h0001, "level");
    // Interrupt line is registered, one cycle behind the flag
    @(negedge clock);
    chk(16'(irq_out_n), 16'h0000, "irq");
    i_host.buf_rd(d);
    chk(16'(d), 16'h00FF, "byte");
    chk(16'(recovered_bit_clock), 16'h0000, "flag clr");
    rx_on = 1'b0;
    i_host.cmd(16'hCE8D, r);
    // Restart with the undefined start code: nothing may be stored
    i_host.cmd(16'hCE8B, r);
    valid_data_indicator = 1'b1;
    rx_on = 1'b1;
    repeat (100) @(negedge clock);
    i_host.cmd(16'h0000, r);
    chk(16'(r[15:11]), 16'h0001, "flushed");
    i_host.cmd(16'hCE83, r);
    repeat (100) @(negedge clock);
    i_host.cmd(16'h0000, r);
    chk(16'(r[15:11]), 16'h0000, "vdi start");
    rx_on = 1'b0;
    $display("test fifo done");
  endtask : t_fifo

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Watchdog well past the expected few thousand cycles
  initial
  begin
    #3000000;
    err_total++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_reset();
    t_status();
    t_ext();
    t_rate();
    t_fifo();
    stop_test();
  end
endmodule : tb_top
